// file: rtl/smc_conv_ctrl.sv
// Conversion sequencing and operating-mode selection
`timescale 1ns/1ns
`default_nettype none

module smc_conv_ctrl #(
    parameter int unsigned RES = smc_pkg::RES_BITS
) (
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    convert_start_n,
    input  wire logic                    comp_keep,
    input  wire smc_pkg::smc_cfg_t       pin_cfg,
    input  wire logic                    sw_config_mode,
    input  wire logic                    cfg_load,
    input  wire smc_pkg::smc_cfg_t       cfg_data,
    output logic                         busy,
    output logic [RES-1:0]               result,
    output logic                         result_valid,
    output logic                         pos_sample_switch,
    output logic                         neg_sample_switch,
    output logic                         array_on_inputs,
    output logic                         array_on_ref,
    output logic [RES-1:0]               capacitor_dac_array,
    output logic                         power_down,
    output smc_pkg::smc_active_t         active_cfg
);

    typedef enum logic [2:0] {
        ST_ACQ,
        ST_OPEN,
        ST_REF,
        ST_WAKE,
        ST_TRIAL,
        ST_CODE
    } smc_state_t;

    localparam logic [smc_pkg::CNT_W-1:0] CNT_ONE = 8'h01;

    smc_state_t                   state;
    smc_state_t                   next_state;
    smc_pkg::smc_cfg_t            cfg_reg;
    smc_pkg::smc_cfg_t            next_cfg_reg;
    smc_pkg::smc_active_t         next_active_cfg;
    logic [smc_pkg::CNT_W-1:0]    cnt;
    logic [smc_pkg::CNT_W-1:0]    next_cnt;
    logic [smc_pkg::CNT_W-1:0]    bit_cyc;
    logic                         prev_cnv;
    logic                         start_fall;
    logic                         acq_done;
    logic                         sar_load;
    logic                         sar_step;
    logic                         sar_done;
    logic [RES-1:0]               next_result;
    logic                         next_busy;
    logic                         next_valid;
    logic                         next_pd;
    logic                         next_sw_closed;
    logic                         next_on_inputs;
    logic                         next_on_ref;
    smc_pkg::smc_cfg_t            src_cfg;

    assign start_fall = prev_cnv && !convert_start_n;
    assign acq_done   = (state == ST_ACQ) && (cnt == smc_pkg::ACQ_CYC);

    smc_sar_reg #(
        .WIDTH     (RES)
    ) u_sar (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .load      (sar_load),
        .step      (sar_step),
        .comp_keep (comp_keep),
        .trial     (capacitor_dac_array),
        .done      (sar_done)
    );

    // Configuration source and active setting
    always_comb begin
        next_cfg_reg = cfg_load ? cfg_data : cfg_reg;
        src_cfg      = sw_config_mode ? cfg_reg : pin_cfg;
        next_active_cfg = active_cfg;
        // Held during conversion so a change never corrupts the trials
        if (state == ST_ACQ) begin
            next_active_cfg.mode  = smc_pkg::decode_mode(src_cfg.mode);
            next_active_cfg.range =
                smc_pkg::decode_range(src_cfg.range);
        end
        unique case (active_cfg.mode)
            smc_pkg::SMC_MODE_FAST:   bit_cyc = smc_pkg::FAST_BIT_CYC;
            smc_pkg::SMC_MODE_LOWPWR: bit_cyc = smc_pkg::LOWPWR_BIT_CYC;
            default:                  bit_cyc = smc_pkg::NORMAL_BIT_CYC;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfg_reg    <= '0;
            active_cfg <= '{smc_pkg::SMC_MODE_NORMAL, smc_pkg::SMC_RANGE_0_5};
        end else begin
            cfg_reg    <= next_cfg_reg;
            active_cfg <= next_active_cfg;
        end
    end

    // Sequencer
    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_result    = result;
        next_busy      = busy;
        next_valid     = 1'b0;
        next_pd        = power_down;
        next_sw_closed = pos_sample_switch;
        next_on_inputs = array_on_inputs;
        next_on_ref    = array_on_ref;
        sar_load       = 1'b0;
        sar_step       = 1'b0;
        unique case (state)
            ST_ACQ: begin
                // A setting change restarts the acquisition count
                if (next_active_cfg != active_cfg) begin
                    next_cnt = '0;
                end else if (cnt != smc_pkg::ACQ_CYC) begin
                    next_cnt = cnt + CNT_ONE;
                end
                // A start that meets a setting change gets no fresh sample
                if (acq_done && start_fall
                    && (next_active_cfg == active_cfg)) begin
                    next_state     = ST_OPEN;
                    next_busy      = 1'b1;
                    next_sw_closed = 1'b0;
                    next_cnt       = '0;
                end
            end
            ST_OPEN: begin
                next_state     = ST_REF;
                next_on_inputs = 1'b0;
                next_on_ref    = 1'b1;
            end
            ST_REF: begin
                if (power_down) begin
                    next_state = ST_WAKE;
                    next_pd    = 1'b0;
                end else begin
                    next_state = ST_TRIAL;
                    sar_load   = 1'b1;
                end
            end
            ST_WAKE: begin
                // Wake-up is paid after sampling, so aperture is unaffected
                next_cnt = cnt + CNT_ONE;
                if (next_cnt == smc_pkg::PWRUP_CYC) begin
                    next_state = ST_TRIAL;
                    next_cnt   = '0;
                    sar_load   = 1'b1;
                end
            end
            ST_TRIAL: begin
                next_cnt = cnt + CNT_ONE;
                if (next_cnt == bit_cyc) begin
                    next_cnt = '0;
                    sar_step = 1'b1;
                end
                if (sar_done) begin
                    next_state  = ST_CODE;
                    next_result = capacitor_dac_array;
                    next_cnt    = '0;
                end
            end
            ST_CODE: begin
                next_state     = ST_ACQ;
                next_busy      = 1'b0;
                next_valid     = 1'b1;
                next_sw_closed = 1'b1;
                next_on_inputs = 1'b1;
                next_on_ref    = 1'b0;
                next_pd        =
                    (active_cfg.mode == smc_pkg::SMC_MODE_LOWPWR);
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state             <= ST_ACQ;
            cnt               <= '0;
            prev_cnv          <= 1'b1;
            result            <= '0;
            busy              <= 1'b0;
            result_valid      <= 1'b0;
            power_down        <= 1'b0;
            pos_sample_switch <= 1'b1;
            neg_sample_switch <= 1'b1;
            array_on_inputs   <= 1'b1;
            array_on_ref      <= 1'b0;
        end else begin
            state             <= next_state;
            cnt               <= next_cnt;
            prev_cnv          <= convert_start_n;
            result            <= next_result;
            busy              <= next_busy;
            result_valid      <= next_valid;
            power_down        <= next_pd;
            pos_sample_switch <= next_sw_closed;
            neg_sample_switch <= next_sw_closed;
            array_on_inputs   <= next_on_inputs;
            array_on_ref      <= next_on_ref;
        end
    end

    // Helper counters for checks
    logic [4:0] step_count;
    logic [8:0] conv_len;
    always_ff @(posedge sys_clk) begin
        if (sys_rst || (start_fall && acq_done)) begin
            step_count <= '0;
            conv_len   <= '0;
        end else begin
            step_count <= step_count + {4'h0, sar_step};
            conv_len   <= conv_len + {8'h00, busy};
        end
    end

    property p_start_after_acq;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(busy) |-> $past(acq_done) && $past(start_fall);
    endproperty
    a_start_after_acq: assert property (p_start_after_acq)
        else $error("conversion began without acquisition and start edge");

    property p_switch_order;
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(pos_sample_switch) |-> array_on_inputs && !array_on_ref
            ##1 !array_on_inputs && array_on_ref && !neg_sample_switch;
    endproperty
    a_switch_order: assert property (p_switch_order)
        else $error("arrays moved before sampling switches opened");

    property p_sixteen_trials;
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(busy) |-> step_count == 5'd16;
    endproperty
    a_sixteen_trials: assert property (p_sixteen_trials)
        else $error("conversion did not run sixteen trials");

    property p_code_before_busy_low;
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(busy) |-> result == $past(capacitor_dac_array) && result_valid
            && $past(busy, 2);
    endproperty
    a_code_before_busy_low: assert property (p_code_before_busy_low)
        else $error("busy fell without the formed code");

    property p_fast_mode;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == ST_ACQ && !sw_config_mode && pin_cfg.mode.fast_sel
            && !pin_cfg.mode.low_power_sel)
        |=> active_cfg.mode == smc_pkg::SMC_MODE_FAST;
    endproperty
    a_fast_mode: assert property (p_fast_mode)
        else $error("fast pins did not select fast mode");

    property p_normal_mode;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == ST_ACQ && !sw_config_mode
            && pin_cfg.mode.fast_sel == pin_cfg.mode.low_power_sel)
        |=> active_cfg.mode == smc_pkg::SMC_MODE_NORMAL;
    endproperty
    a_normal_mode: assert property (p_normal_mode)
        else $error("equal pins did not select normal mode");

    property p_lowpwr_mode;
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(busy) && active_cfg.mode == smc_pkg::SMC_MODE_LOWPWR
        |-> power_down;
    endproperty
    a_lowpwr_mode: assert property (p_lowpwr_mode)
        else $error("low-power mode did not power down after conversion");

    property p_sw_config;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == ST_ACQ && sw_config_mode)
        |=> active_cfg.mode == smc_pkg::decode_mode($past(cfg_reg.mode));
    endproperty
    a_sw_config: assert property (p_sw_config)
        else $error("software mode did not follow the config register");

    property p_throughput;
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(busy) |-> conv_len + 9'(smc_pkg::ACQ_CYC_I) <= 9'(
            active_cfg.mode == smc_pkg::SMC_MODE_FAST ? smc_pkg::FAST_PER_CYC
          : active_cfg.mode == smc_pkg::SMC_MODE_LOWPWR
            ? smc_pkg::LOWPWR_PER_CYC : smc_pkg::NORMAL_PER_CYC);
    endproperty
    a_throughput: assert property (p_throughput)
        else $error("conversion too long for the mode's throughput");

    property p_setting_settles;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == ST_ACQ && next_active_cfg != active_cfg) |=> !busy [*2];
    endproperty
    a_setting_settles: assert property (p_setting_settles)
        else $error("conversion began before a new setting settled");

    property p_ignore_while_busy;
        @(posedge sys_clk) disable iff (sys_rst)
        busy && start_fall |=> busy || $past(state) == ST_CODE;
    endproperty
    a_ignore_while_busy: assert property (p_ignore_while_busy)
        else $error("start edge disturbed a running conversion");

    c_fast_done: cover property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(busy) && active_cfg.mode == smc_pkg::SMC_MODE_FAST);
    c_lowpwr_done: cover property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(busy) && active_cfg.mode == smc_pkg::SMC_MODE_LOWPWR);
    c_start_ignored: cover property (@(posedge sys_clk) disable iff (sys_rst)
        busy && start_fall);
    c_sw_config: cover property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(busy) && sw_config_mode);

endmodule // smc_conv_ctrl

`default_nettype wire

// file: rtl/smc_pkg.sv
// Constants, types and decode helpers for the conversion and mode control
package smc_pkg;

    localparam int unsigned RES_BITS      = 16;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned CNT_W         = 8;

    // Throughput figures in kSPS
    localparam int unsigned FAST_KSPS     = 750;
    localparam int unsigned FAST_MAX_KSPS = 900;
    localparam int unsigned NORMAL_KSPS   = 600;
    localparam int unsigned LOWPWR_KSPS   = 500;

    // Sample periods in cycles, rounded down
    localparam int unsigned FAST_PER_CYC   =
        1000000 / (FAST_MAX_KSPS * CLK_PERIOD_NS);
    localparam int unsigned NORMAL_PER_CYC =
        1000000 / (NORMAL_KSPS * CLK_PERIOD_NS);
    localparam int unsigned LOWPWR_PER_CYC =
        1000000 / (LOWPWR_KSPS * CLK_PERIOD_NS);

    // Least acquisition and wake-up times, rounded up
    localparam int unsigned ACQ_NS    = 250;
    localparam int unsigned PWRUP_NS  = 40;
    localparam int unsigned ACQ_CYC_I =
        (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PWRUP_CYC_I =
        (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] ACQ_CYC   = CNT_W'(ACQ_CYC_I);
    localparam logic [CNT_W-1:0] PWRUP_CYC = CNT_W'(PWRUP_CYC_I);

    // Open, to-ref, code and hand-back cycles around the trials
    localparam int unsigned FIXED_CYC = 4;

    // Cycles per bit trial, sized so each mode meets its throughput
    localparam logic [CNT_W-1:0] FAST_BIT_CYC = CNT_W'(
        (FAST_PER_CYC - ACQ_CYC_I - FIXED_CYC) / RES_BITS);
    localparam logic [CNT_W-1:0] NORMAL_BIT_CYC = CNT_W'(
        (NORMAL_PER_CYC - ACQ_CYC_I - FIXED_CYC) / RES_BITS);
    localparam logic [CNT_W-1:0] LOWPWR_BIT_CYC = CNT_W'(
        (LOWPWR_PER_CYC - ACQ_CYC_I - FIXED_CYC - PWRUP_CYC_I)
        / RES_BITS);

    typedef enum logic [1:0] {
        SMC_MODE_NORMAL,
        SMC_MODE_FAST,
        SMC_MODE_LOWPWR
    } smc_mode_t;

    typedef enum logic [1:0] {
        SMC_RANGE_0_5,
        SMC_RANGE_0_10,
        SMC_RANGE_PM5,
        SMC_RANGE_PM10
    } smc_range_t;

    typedef struct packed {
        logic fast_sel;
        logic low_power_sel;
    } smc_mode_pins_t;

    typedef struct packed {
        logic bipolar_sel;
        logic ten_volt_sel;
    } smc_range_pins_t;

    typedef struct packed {
        smc_mode_pins_t  mode;
        smc_range_pins_t range;
    } smc_cfg_t;

    typedef struct packed {
        smc_mode_t  mode;
        smc_range_t range;
    } smc_active_t;

    function automatic smc_mode_t decode_mode(input smc_mode_pins_t p);
        smc_mode_t m;
        m = SMC_MODE_NORMAL;
        if (p.fast_sel && !p.low_power_sel) begin
            m = SMC_MODE_FAST;
        end else if (!p.fast_sel && p.low_power_sel) begin
            m = SMC_MODE_LOWPWR;
        end
        return m;
    endfunction

    function automatic smc_range_t decode_range(input smc_range_pins_t p);
        return smc_range_t'({p.bipolar_sel, p.ten_volt_sel});
    endfunction

endpackage

// file: rtl/smc_sar_reg.sv
// Successive approximation register, MSB first, one trial per step
`timescale 1ns/1ns
`default_nettype none

module smc_sar_reg #(
    parameter int unsigned WIDTH = smc_pkg::RES_BITS
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             load,
    input  wire logic             step,
    input  wire logic             comp_keep,
    output logic [WIDTH-1:0]      trial,
    output logic                  done
);

    logic [WIDTH-1:0] ptr;
    logic [WIDTH-1:0] next_trial;
    logic [WIDTH-1:0] next_ptr;
    logic             next_done;

    always_comb begin
        next_trial = trial;
        next_ptr   = ptr;
        next_done  = 1'b0;
        if (load) begin
            // Half-reference step first
            next_ptr   = {1'b1, {(WIDTH-1){1'b0}}};
            next_trial = next_ptr;
        end else if (step && (ptr != '0)) begin
            // Drop the bit if the comparator says too high
            next_trial = (comp_keep ? trial : (trial & ~ptr)) | (ptr >> 1);
            next_ptr   = ptr >> 1;
            next_done  = (ptr == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            trial <= '0;
            ptr   <= '0;
            done  <= 1'b0;
        end else begin
            trial <= next_trial;
            ptr   <= next_ptr;
            done  <= next_done;
        end
    end

endmodule // smc_sar_reg

`default_nettype wire

// file: tb/smc_host_model.sv
// Host controller model that issues convert starts
`timescale 1ns/1ns
`default_nettype none

module smc_host_model (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic busy,
    input  wire logic go,
    input  wire logic polite,
    output logic      convert_start_n,
    output logic      discard
);
    logic        pend;
    logic        fire;
    logic [7:0]  idle;
    logic [16:0] gap;

    initial begin
        pend = 1'b0;
        idle = 8'h00;
        gap = 17'h00000;
        convert_start_n = 1'b1;
        discard = 1'b0;
    end

    // A rude host fires at once, even while busy
    assign fire = pend && (!polite || (!busy && idle >= 8'd40));

    always @(posedge sys_clk) begin
        if (busy || sys_rst) begin
            idle <= 8'h00;
        end else if (idle != 8'hff) begin
            idle <= idle + 8'h01;
        end
        if (sys_rst) begin
            pend <= 1'b0;
        end else if (go) begin
            pend <= 1'b1;
        end else if (fire) begin
            pend <= 1'b0;
        end
        convert_start_n <= !fire;
        // Stale calibration after a long gap: drop that result
        if (!convert_start_n) begin
            gap <= 17'h00000;
            discard <= (gap > 17'd125000);
        end else if (gap != 17'h1ffff) begin
            gap <= gap + 17'h00001;
        end
    end
endmodule // smc_host_model

`default_nettype wire

// file: tb/tb_smc_conv_ctrl.sv
// Self-checking bench for conversion sequencing and mode control
`timescale 1ns/1ns
`default_nettype none

module tb_smc_conv_ctrl;
    logic                 sys_clk = 1'b0;
    logic                 sys_rst = 1'b1;
    logic                 comp_keep = 1'b0;
    logic                 sw_config_mode = 1'b0;
    logic                 cfg_load = 1'b0;
    logic                 go = 1'b0;
    logic                 polite = 1'b1;
    smc_pkg::smc_cfg_t    pin_cfg = '0;
    smc_pkg::smc_cfg_t    cfg_data = '0;
    logic [15:0]          analog = 16'h0000;
    logic [15:0]          held = 16'h0000;
    logic                 busy_q = 1'b0;
    logic                 busy;
    logic                 result_valid;
    logic                 pos_sw;
    logic                 neg_sw;
    logic                 on_in;
    logic                 on_ref;
    logic                 power_down;
    logic                 convert_start_n;
    logic [15:0]          result;
    logic [15:0]          dac;
    smc_pkg::smc_active_t active_cfg;
    int                   miscompares = 0;
    int                   total_checks = 0;
    int                   cyc = 0;
    int                   len_n;
    int                   len_x;

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    smc_conv_ctrl u_dut (
        .sys_clk             (sys_clk),
        .sys_rst             (sys_rst),
        .convert_start_n     (convert_start_n),
        .comp_keep           (comp_keep),
        .pin_cfg             (pin_cfg),
        .sw_config_mode      (sw_config_mode),
        .cfg_load            (cfg_load),
        .cfg_data            (cfg_data),
        .busy                (busy),
        .result              (result),
        .result_valid        (result_valid),
        .pos_sample_switch   (pos_sw),
        .neg_sample_switch   (neg_sw),
        .array_on_inputs     (on_in),
        .array_on_ref        (on_ref),
        .capacitor_dac_array (dac),
        .power_down          (power_down),
        .active_cfg          (active_cfg)
    );

    smc_host_model u_host (
        .sys_clk         (sys_clk),
        .sys_rst         (sys_rst),
        .busy            (busy),
        .go              (go),
        .polite          (polite),
        .convert_start_n (convert_start_n),
        .discard         ()
    );

    // Ideal comparator on the sample held when busy rises
    always @(posedge sys_clk) begin
        busy_q <= busy;
        if (busy && !busy_q) begin
            held <= analog;
        end
        comp_keep <= (dac <= held);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            $display("Error at %0t: timeout", $time);
            wrap_up();
        end
    end

    task automatic chk(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic set_cfg(input logic [3:0] v);
        @(posedge sys_clk);
        pin_cfg <= smc_pkg::smc_cfg_t'(v);
        repeat (40) @(posedge sys_clk);
    endtask

    // Input changes after the start must not reach the result
    task automatic do_conv(input logic [15:0] v, input int per,
                           input logic pd, input logic poke,
                           output int len);
        int          n;
        logic [15:0] first;
        logic        pd0;
        @(posedge sys_clk);
        analog <= v;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        n = 0;
        first = 16'h0000;
        while (busy !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        pd0 = power_down;
        chk(!pos_sw && !neg_sw && !on_ref, "switch order");
        @(posedge sys_clk);
        analog <= ~v;
        #1;
        chk(on_ref === 1'b1 && on_in === 1'b0, "array move");
        @(posedge sys_clk);
        polite <= !poke;
        go <= poke;
        @(posedge sys_clk);
        go <= 1'b0;
        #1;
        len = 4;
        while (busy === 1'b1 && len < 400) begin
            // Old code lingers until load, five cycles later after a wake
            if (len == (pd0 ? 8 : 4)) begin
                first = dac;
            end
            tick(1);
            if (busy === 1'b1) begin
                len++;
            end
        end
        chk(result_valid === 1'b1 && busy === 1'b0, "busy end");
        chk(result === v, "result code");
        chk(first === 16'h8000, "first trial");
        chk(len + smc_pkg::ACQ_CYC_I <= per, "throughput");
        chk(power_down === pd, "power down");
        @(posedge sys_clk);
        polite <= 1'b1;
        tick(40);
        chk(busy === 1'b0, "start remembered");
    endtask

    task automatic t_modes;
        smc_pkg::smc_mode_t m;
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            pin_cfg <= smc_pkg::smc_cfg_t'(i[3:0]);
            tick(3);
            m = smc_pkg::SMC_MODE_NORMAL;
            if (i[3] && !i[2]) begin
                m = smc_pkg::SMC_MODE_FAST;
            end else if (!i[3] && i[2]) begin
                m = smc_pkg::SMC_MODE_LOWPWR;
            end
            chk(active_cfg.mode === m, "mode decode");
            chk(active_cfg.range === smc_pkg::smc_range_t'(i[1:0]),
                "range decode");
        end
    endtask

    // Setting change restarts acquisition, so an early start is dropped
    task automatic t_refuse;
        @(posedge sys_clk);
        pin_cfg <= smc_pkg::smc_cfg_t'(4'b0000);
        polite <= 1'b0;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (2) @(posedge sys_clk);
        polite <= 1'b1;
        tick(10);
        chk(busy === 1'b0, "early start taken");
        repeat (40) @(posedge sys_clk);
        do_conv(16'h5a5a, 208, 1'b0, 1'b0, len_x);
    endtask

    task automatic t_sw;
        @(posedge sys_clk);
        sw_config_mode <= 1'b1;
        cfg_data <= smc_pkg::smc_cfg_t'(4'b1011);
        cfg_load <= 1'b1;
        @(posedge sys_clk);
        cfg_load <= 1'b0;
        pin_cfg <= smc_pkg::smc_cfg_t'(4'b0100);
        tick(4);
        chk(active_cfg.mode === smc_pkg::SMC_MODE_FAST, "sw mode");
        chk(active_cfg.range === smc_pkg::SMC_RANGE_PM10, "sw range");
        repeat (40) @(posedge sys_clk);
        do_conv(16'h1234, 138, 1'b0, 1'b0, len_x);
    endtask

    task automatic wrap_up;
        $display("Checks %0d, miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        tick(1);
        chk(!busy && !result_valid && result === 16'h0000, "reset");
        chk(pos_sw && neg_sw && on_in && !on_ref, "reset sw");
        t_modes();
        set_cfg(4'b0000);
        do_conv(16'ha5a5, 208, 1'b0, 1'b0, len_n);
        do_conv(16'h0000, 208, 1'b0, 1'b0, len_x);
        do_conv(16'hffff, 208, 1'b0, 1'b1, len_x);
        chk(len_x === len_n, "busy restarted");
        set_cfg(4'b1000);
        do_conv(16'h8000, 138, 1'b0, 1'b0, len_x);
        set_cfg(4'b1100);
        do_conv(16'h0001, 208, 1'b0, 1'b0, len_x);
        set_cfg(4'b0100);
        do_conv(16'h7ffe, 250, 1'b1, 1'b0, len_x);
        t_refuse();
        t_sw();
        wrap_up();
    end
endmodule // tb_smc_conv_ctrl

`default_nettype wire
